// ==== hw/arim_relay_module.sv ====
// Addressable relay module core with dry-contact input reporting
// Operation
// R1: Bus address is binary from switches one to five, switch one least significant.
// R2: Addresses span 1 to 32; each module address unique and matching host setup.
// R3: An eight-channel analog module takes eight consecutive addresses reserved by host.
// R4: Switches six and seven are unused; module ignores them.
// R5: Switch eight enables line termination, only on the last module.
// R6: Host connects at most five modules per line, ten on two lines.
// R7: Polarity on keeps coil energized out of alarm; off energizes in alarm.
// R8: Polarity switch n acts on relay n; four-relay build uses only four.
// R9: Two-line host drives at most sixteen relays on four relay modules.
// R10: Any detector event may be assigned to relays; assigned events are ORed.
// R11: Normal mode relay is active exactly while its condition is active.
// R12: Sounder mode relay activates normally; acknowledge silences it despite alarm.
// R13: Sounder relay ignores acknowledge until active for inhibit time 0 to 900 s.
// R14: With auto reset, sounder relay drops after 15 to 900 s active.
// R15: With reactivation, silenced relay with persisting alarm returns after 15 to 900 s.
// R16: Relay may follow a boolean equation of OR, AND, NOR, NAND over events.
// R17: Vote mode activates at x of y events; failures optionally count.
// R18: Each relay indicator is lit exactly while its coil is powered.
// R19: Sixteen dry contacts reported to host; open contact means alarm.
// R20: Host handles at most sixteen contact inputs from two input modules.
// R21: Relay timers count a one-second tick from the clock, values from host.
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`default_nettype none
module arim_relay_module
	import arim_pkg::*;
#(
	parameter int N_RELAY = REL_MAX,
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Configuration switches
	input wire logic [4:0] addr_sw,
	input wire logic term_sw,
	input wire logic [REL_MAX-1:0] polarity_sw,
	// Field side
	input wire logic [CONTACT_W-1:0] contact_closed,
	output logic [REL_MAX-1:0] relay_coil,
	output logic [REL_MAX-1:0] relay_led,
	output logic line_termination_enable
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (N_RELAY != 4 && N_RELAY != 8) begin : g_bad_n
		$error("N_RELAY must be 4 or 8");
	end
	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("TICK_CYCLES must be at least 1");
	end

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Timer limits keep a bad host value inside the documented span
	function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo);
		logic [9:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > T_TIMER_MAX_S) begin
			r = T_TIMER_MAX_S;
		end
		return r;
	endfunction : clamp

	function automatic logic reduce(input logic [EVT_W-1:0] ev, input logic [EVT_W-1:0] msk,
		input arim_op_t op);
		logic r;
		r = 1'b0;
		case (op)
			OP_OR: r = |(ev & msk);
			OP_AND: r = (msk != '0) && ((ev & msk) == msk);
			OP_NOR: r = ~|(ev & msk);
			OP_NAND: r = ~((msk != '0) && ((ev & msk) == msk));
			default: r = 1'b0;
		endcase
		return r;
	endfunction : reduce

	function automatic logic combine(input logic a, input logic b, input arim_op_t op);
		logic r;
		r = 1'b0;
		case (op)
			OP_OR: r = a | b;
			OP_AND: r = a & b;
			OP_NOR: r = ~(a | b);
			OP_NAND: r = ~(a & b);
			default: r = 1'b0;
		endcase
		return r;
	endfunction : combine

	function automatic logic [4:0] popcount(input logic [EVT_W-1:0] v);
		logic [4:0] c;
		c = 5'h00;
		for (int k = 0; k < EVT_W; k++) begin
			c = c + {4'h0, v[k]};
		end
		return c;
	endfunction : popcount

	// ----------------------------------------
	// State
	// ----------------------------------------
	arim_state_t s_reg;
	arim_state_t s_next;

	logic [5:0] module_addr;
	logic [REL_MAX-1:0] pol_eff;
	logic [CONTACT_W-1:0] contact_alarm;

	// Only switches one to five form the address; six and seven go unread. R1 R4
	// The all-off setting stands for address 32 so the span is 1 to 32. R2
	assign module_addr = (addr_sw == 5'h00) ? ADDR_MAX : {1'b0, addr_sw};
	// A relay module answers on one address; the host keeps addresses unique. R3 R6
	assign line_termination_enable = term_sw; // R5
	// Polarity bits beyond the fitted relays have no effect. R8
	assign pol_eff = polarity_sw & REL_MAX'((1 << N_RELAY) - 1);
	assign contact_alarm = ~contact_closed; // R19

	// Waitrequest drops one cycle after the request; read data then stands
	assign avs_waitrequest = (avs_read | avs_write) & ~s_reg.bus_ack;
	assign avs_readdata = s_reg.rdata;
	assign relay_coil = s_reg.coil;
	assign relay_led = s_reg.coil; // R18

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic wr_now;
		logic rd_now;
		logic [7:0] wa;
		logic [31:0] rd;
		logic [EVT_W-1:0] ev;
		logic [EVT_W-1:0] vote_ev;
		logic [15:0] ct;
		logic [29:0] tm;
		logic [31:0] mk;
		logic cond;
		logic act;
		logic ack_i;
		logic [9:0] sec_inc;
		wr_now = 1'b0;
		rd_now = 1'b0;
		wa = 8'h00;
		rd = 32'h0000_0000;
		ev = '0;
		vote_ev = '0;
		ct = 16'h0000;
		tm = 30'h0000_0000;
		mk = 32'h0000_0000;
		cond = 1'b0;
		act = 1'b0;
		ack_i = 1'b0;
		sec_inc = 10'h000;
		s_next = s_reg;

		// Bus handshake: take the request, answer on the next edge
		s_next.bus_ack = (avs_read | avs_write) & ~s_reg.bus_ack;
		wr_now = avs_write & s_reg.bus_ack;
		rd_now = avs_read & ~s_reg.bus_ack;
		wa = {avs_address[7:2], 2'b00};

		// One-second tick for all relay timers R21
		if (s_reg.tick_cnt == 32'(TICK_CYCLES - 1)) begin
			s_next.tick_cnt = 32'h0000_0000;
			s_next.tick = 1'b1;
		end else begin
			s_next.tick_cnt = s_reg.tick_cnt + 32'h0000_0001;
			s_next.tick = 1'b0;
		end

		// Register writes
		if (wr_now) begin
			if (wa == OFS_EVENTS) begin
				s_next.events = EVT_W'(merge(32'(s_reg.events), avs_writedata, avs_byteenable));
			end else if (wa == OFS_FAIL_MASK) begin
				s_next.fail_mask = EVT_W'(merge(32'(s_reg.fail_mask), avs_writedata,
					avs_byteenable));
			end
			for (int i = 0; i < N_RELAY; i++) begin
				if (wa == OFS_RELAY_BASE + 8'(i) * OFS_RELAY_STRIDE + OFS_R_MASKS) begin
					s_next.masks[i] = merge(s_reg.masks[i], avs_writedata, avs_byteenable);
				end
				if (wa == OFS_RELAY_BASE + 8'(i) * OFS_RELAY_STRIDE + OFS_R_CTRL) begin
					s_next.ctrl[i] = 16'(merge(32'(s_reg.ctrl[i]), avs_writedata,
						avs_byteenable));
				end
				if (wa == OFS_RELAY_BASE + 8'(i) * OFS_RELAY_STRIDE + OFS_R_TIMES) begin
					s_next.times[i] = 30'(merge(32'(s_reg.times[i]), avs_writedata,
						avs_byteenable));
				end
			end
		end

		// Register reads; unmapped offsets read zero
		if (rd_now) begin
			if (wa == OFS_STATUS) begin
				rd[ST_ADDR_LSB +: 6] = module_addr;
				rd[ST_TERM_BIT] = term_sw;
				rd[ST_COIL_LSB +: REL_MAX] = s_reg.coil;
			end else if (wa == OFS_EVENTS) begin
				rd[EVT_W-1:0] = s_reg.events;
			end else if (wa == OFS_FAIL_MASK) begin
				rd[EVT_W-1:0] = s_reg.fail_mask;
			end else if (wa == OFS_CONTACT) begin
				rd[CONTACT_W-1:0] = contact_alarm; // R19
			end
			for (int i = 0; i < N_RELAY; i++) begin
				if (wa == OFS_RELAY_BASE + 8'(i) * OFS_RELAY_STRIDE + OFS_R_MASKS) begin
					rd = s_reg.masks[i];
				end
				if (wa == OFS_RELAY_BASE + 8'(i) * OFS_RELAY_STRIDE + OFS_R_CTRL) begin
					rd = {16'h0000, s_reg.ctrl[i]};
				end
				if (wa == OFS_RELAY_BASE + 8'(i) * OFS_RELAY_STRIDE + OFS_R_TIMES) begin
					rd = {2'b00, s_reg.times[i]};
				end
			end
			s_next.rdata = rd;
		end

		// Relay evaluation, the host owns the event picture
		ev = s_reg.events;
		for (int i = 0; i < REL_MAX; i++) begin
			ct = s_reg.ctrl[i];
			tm = s_reg.times[i];
			mk = s_reg.masks[i];
			ack_i = wr_now && (wa == OFS_ACK) && avs_writedata[i] && avs_byteenable[i/8];
			// Assigned events are ORed into the relay condition R10
			cond = reduce(ev, mk[EVT_W-1:0], OP_OR);
			case (arim_mode_t'(ct[CT_MODE_LSB +: 2]))
				MODE_LOGIC: begin
					// Two groups each reduced, then joined by the outer operator R16
					cond = combine(reduce(ev, mk[EVT_W-1:0], arim_op_t'(ct[CT_OPA_LSB +: 2])),
						reduce(ev, mk[31:16], arim_op_t'(ct[CT_OPB_LSB +: 2])),
						arim_op_t'(ct[CT_OPO_LSB +: 2]));
				end
				MODE_VOTE: begin
					// Failure events count only when the option is set R17
					vote_ev = ev & mk[EVT_W-1:0];
					if (!ct[CT_FAILAL_BIT]) begin
						vote_ev = vote_ev & ~s_reg.fail_mask;
					end
					cond = (ct[CT_VOTE_LSB +: 5] != 5'h00) &&
						(popcount(vote_ev) >= ct[CT_VOTE_LSB +: 5]);
				end
				default: begin
				end
			endcase

			sec_inc = (s_reg.secs[i] == 10'h3FF) ? s_reg.secs[i] :
				s_reg.secs[i] + {9'h000, s_reg.tick};
			if (arim_mode_t'(ct[CT_MODE_LSB +: 2]) != MODE_SOUNDER) begin
				s_next.st[i] = RS_IDLE;
				s_next.secs[i] = 10'h000;
				act = cond; // R11
			end else begin
				case (s_reg.st[i])
					RS_IDLE: begin
						if (cond) begin
							s_next.st[i] = RS_ON; // R12
						end
						s_next.secs[i] = 10'h000;
					end
					RS_ON: begin
						if (!cond) begin
							s_next.st[i] = RS_IDLE;
							s_next.secs[i] = 10'h000;
						end else if (ack_i && s_reg.secs[i] >=
							clamp(tm[TM_INH_LSB +: 10], T_INHIBIT_MIN_S)) begin
							// Acknowledge silences despite the alarm R12 R13
							s_next.st[i] = RS_SILENT;
							s_next.secs[i] = 10'h000;
						end else if (ct[CT_AUTO_BIT] && s_reg.secs[i] >=
							clamp(tm[TM_AUTO_LSB +: 10], T_TIMER_MIN_S)) begin
							s_next.st[i] = RS_SILENT; // R14
							s_next.secs[i] = 10'h000;
						end else begin
							s_next.secs[i] = sec_inc; // R21
						end
					end
					RS_SILENT: begin
						if (!cond) begin
							s_next.st[i] = RS_IDLE;
							s_next.secs[i] = 10'h000;
						end else if (ct[CT_REACT_BIT] && s_reg.secs[i] >=
							clamp(tm[TM_REACT_LSB +: 10], T_TIMER_MIN_S)) begin
							s_next.st[i] = RS_ON; // R15
							s_next.secs[i] = 10'h000;
						end else begin
							s_next.secs[i] = sec_inc;
						end
					end
					default: begin
						s_next.st[i] = RS_IDLE;
						s_next.secs[i] = 10'h000;
					end
				endcase
				act = (s_reg.st[i] == RS_ON);
			end

			// Polarity decides whether the coil rests energized R7 R8
			if (i < N_RELAY) begin
				s_next.coil[i] = pol_eff[i] ? ~act : act;
			end else begin
				s_next.coil[i] = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg.bus_ack <= 1'b0;
			s_reg.rdata <= 32'h0000_0000;
			s_reg.events <= RST_EVENTS;
			s_reg.fail_mask <= RST_FAIL_MASK;
			s_reg.masks <= {REL_MAX{RST_MASKS}};
			s_reg.ctrl <= {REL_MAX{RST_CTRL}};
			s_reg.times <= {REL_MAX{RST_TIMES}};
			s_reg.st <= {REL_MAX{RS_IDLE}};
			s_reg.secs <= '0;
			s_reg.tick_cnt <= 32'h0000_0000;
			s_reg.tick <= 1'b0;
			s_reg.coil <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule : arim_relay_module
`default_nettype wire

// ==== hw/arim_pkg.sv ====
// Package for the addressable relay and contact input module
`default_nettype none
package arim_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_PERIOD_S = 1;
	localparam int TICK_CYCLES_DEF = CLK_HZ * TICK_PERIOD_S;

	// ----------------------------------------
	// Sizes and limits
	// ----------------------------------------
	localparam int REL_MAX = 8;
	localparam int EVT_W = 16;
	localparam int CONTACT_W = 16;
	localparam int ADDR_W = 8;
	localparam logic [5:0] ADDR_MAX = 6'h20;
	localparam logic [9:0] T_INHIBIT_MIN_S = 10'h000;
	localparam logic [9:0] T_TIMER_MIN_S = 10'h00F;
	localparam logic [9:0] T_TIMER_MAX_S = 10'h384;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_EVENTS = 8'h04;
	localparam logic [7:0] OFS_FAIL_MASK = 8'h08;
	localparam logic [7:0] OFS_ACK = 8'h0C;
	localparam logic [7:0] OFS_CONTACT = 8'h10;
	localparam logic [7:0] OFS_RELAY_BASE = 8'h40;
	localparam logic [7:0] OFS_RELAY_STRIDE = 8'h10;
	localparam logic [7:0] OFS_R_MASKS = 8'h00;
	localparam logic [7:0] OFS_R_CTRL = 8'h04;
	localparam logic [7:0] OFS_R_TIMES = 8'h08;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ST_ADDR_LSB = 0;
	localparam int ST_TERM_BIT = 8;
	localparam int ST_COIL_LSB = 16;
	localparam int CT_MODE_LSB = 0;
	localparam int CT_OPA_LSB = 2;
	localparam int CT_OPB_LSB = 4;
	localparam int CT_OPO_LSB = 6;
	localparam int CT_VOTE_LSB = 8;
	localparam int CT_FAILAL_BIT = 13;
	localparam int CT_AUTO_BIT = 14;
	localparam int CT_REACT_BIT = 15;
	localparam int TM_INH_LSB = 0;
	localparam int TM_AUTO_LSB = 10;
	localparam int TM_REACT_LSB = 20;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_EVENTS = 16'h0000;
	localparam logic [15:0] RST_FAIL_MASK = 16'h0000;
	localparam logic [31:0] RST_MASKS = 32'h0000_0000;
	localparam logic [15:0] RST_CTRL = 16'h0000;
	localparam logic [29:0] RST_TIMES = 30'h0000_0000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {MODE_NORMAL, MODE_SOUNDER, MODE_LOGIC, MODE_VOTE} arim_mode_t;
	typedef enum logic [1:0] {OP_OR, OP_AND, OP_NOR, OP_NAND} arim_op_t;
	typedef enum logic [1:0] {RS_IDLE, RS_ON, RS_SILENT} arim_rly_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} arim_avs_req_t;

	typedef struct packed {
		logic bus_ack;
		logic [31:0] rdata;
		logic [EVT_W-1:0] events;
		logic [EVT_W-1:0] fail_mask;
		logic [REL_MAX-1:0][31:0] masks;
		logic [REL_MAX-1:0][15:0] ctrl;
		logic [REL_MAX-1:0][29:0] times;
		arim_rly_t [REL_MAX-1:0] st;
		logic [REL_MAX-1:0][9:0] secs;
		logic [31:0] tick_cnt;
		logic tick;
		logic [REL_MAX-1:0] coil;
	} arim_state_t;

endpackage : arim_pkg
`default_nettype wire

// ==== verification/arim_relay_module_sva.sv ====
// Port-level checker for the addressable relay module
`default_nettype none
module arim_relay_module_sva
	import arim_pkg::*;
#(
	parameter int N_RELAY = REL_MAX,
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Switches and field side
	input wire logic [4:0] addr_sw,
	input wire logic term_sw,
	input wire logic [REL_MAX-1:0] polarity_sw,
	input wire logic [CONTACT_W-1:0] contact_closed,
	input wire logic [REL_MAX-1:0] relay_coil,
	input wire logic [REL_MAX-1:0] relay_led,
	input wire logic line_termination_enable
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] RMASK = 8'((9'h001 << N_RELAY) - 9'h001);
	wire logic req = avs_read | avs_write;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Bus phases
	// ----------------------------------------
	sequence s_wait;
		req && avs_waitrequest;
	endsequence
	sequence s_rdone;
		avs_read && !avs_waitrequest;
	endsequence
	AST_ONE_WAIT: assert property (s_wait |=> req && !avs_waitrequest)
		else $error("request waited more than one cycle");
	AST_FIRST_WAIT: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
		else $error("request answered without a wait cycle");
	AST_RD_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	AST_STATUS: assert property (s_rdone ##0 (avs_address[7:2] == 6'h00) |->
		avs_readdata[23:16] == $past(relay_coil) && avs_readdata[8] == $past(term_sw) &&
		avs_readdata[5:0] == (($past(addr_sw) == 5'h00) ? 6'h20 : {1'b0, $past(addr_sw)}))
		else $error("status word wrong");
	AST_CONTACT: assert property (s_rdone ##0 (avs_address[7:2] == 6'h04) |->
		avs_readdata[15:0] == ~$past(contact_closed))
		else $error("contact word wrong");
	AST_UNMAP: assert property (s_rdone ##0 (avs_address inside {[8'h14:8'h3F]}) |->
		avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	// ----------------------------------------
	// Field side
	// ----------------------------------------
	AST_TERM: assert property (line_termination_enable == term_sw)
		else $error("termination differs from switch");
	AST_LED: assert property (relay_led == relay_coil)
		else $error("indicator differs from coil");
	AST_UNUSED: assert property ((relay_coil & ~RMASK) == 8'h00)
		else $error("coil beyond relay count driven");
	AST_POL_RST: assert property ($rose(rst_n) |=> relay_coil == ($past(polarity_sw) & RMASK))
		else $error("rest coil differs from polarity");
endmodule : arim_relay_module_sva
bind arim_relay_module arim_relay_module_sva #(
	.N_RELAY(N_RELAY), .TICK_CYCLES(TICK_CYCLES)
) i_sva (
	.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .addr_sw(addr_sw),
	.term_sw(term_sw), .polarity_sw(polarity_sw), .contact_closed(contact_closed),
	.relay_coil(relay_coil), .relay_led(relay_led),
	.line_termination_enable(line_termination_enable)
);
`default_nettype wire

// ==== verification/arim_host_model.sv ====
// Host controller model: bus master that configures and polls the module
`default_nettype none
module arim_host_model
	import arim_pkg::*;
(
	// Clock
	input wire logic clock,
	// Avalon-MM master
	output logic [ADDR_W-1:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
	end
	// One word per access; released lines show inverted values, not the stale ones
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		int n;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		q = avs_readdata;
		ok = (avs_waitrequest === 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask : xfer
endmodule : arim_host_model
`default_nettype wire

// ==== verification/arim_relay_module_tb.sv ====
// Self-checking testbench for the addressable relay module
`default_nettype none
module arim_relay_module_tb import arim_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TK = 10;
	localparam logic [3:0] LOGIC_EXP = 4'h9;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic [4:0] addr_sw;
	logic term_sw, line_termination_enable, ok;
	logic [7:0] polarity_sw, relay_coil, relay_led;
	logic [7:0] coil_four, led_four;
	logic term_four;
	logic [15:0] contact_closed;
	int miscompares = 0;
	int n_tests = 0;
	always #2.5 clock = ~clock;
	arim_relay_module #(.N_RELAY(8), .TICK_CYCLES(TK)) i_dut (
		.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .addr_sw(addr_sw),
		.term_sw(term_sw), .polarity_sw(polarity_sw), .contact_closed(contact_closed),
		.relay_coil(relay_coil), .relay_led(relay_led),
		.line_termination_enable(line_termination_enable));
	// Four-relay build on the same bus: fitted relays mirror, the rest stay dark
	arim_relay_module #(.N_RELAY(4), .TICK_CYCLES(TK)) i_dut_four (
		.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(), .avs_waitrequest(), .addr_sw(addr_sw),
		.term_sw(term_sw), .polarity_sw(polarity_sw), .contact_closed(contact_closed),
		.relay_coil(coil_four), .relay_led(led_four),
		.line_termination_enable(term_four));
	arim_host_model i_host (
		.clock(clock), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic io(input logic [7:0] a, input logic w, input logic [31:0] d);
		i_host.xfer(a, w, d, q, ok);
		if (ok !== 1'b1) begin
			miscompares++;
			$display("[ERR] %0t bus timeout", $time);
			close_out();
		end
	endtask : io
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		io(a, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		io(a, 1'b0, 32'h0000_0000);
		chk(q, exp);
	endtask : rd
	// Coil follows a write two edges later; three leaves margin
	task automatic coil(input logic [7:0] act);
		repeat (3) @(posedge clock);
		chk({16'h0000, relay_led, relay_coil}, {16'h0000, {2{polarity_sw ^ act}}});
		chk({16'h0000, led_four, coil_four}, {16'h0000, {2{(polarity_sw ^ act) & 8'h0F}}});
	endtask : coil
	task automatic secs(input int s);
		repeat (s * TK) @(posedge clock);
	endtask : secs
	function automatic logic [7:0] ra(input int i, input logic [7:0] o);
		return OFS_RELAY_BASE + OFS_RELAY_STRIDE * 8'(i) + o;
	endfunction : ra
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		addr_sw = 5'h09;
		term_sw = 1'b1;
		polarity_sw = 8'hA5;
		contact_closed = 16'hFF0F;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		coil(8'h00);
		chk({31'h0000_0000, line_termination_enable}, 32'h0000_0001);
		rd(OFS_STATUS, 32'h00A5_0109);
		addr_sw <= 5'h00;
		term_sw <= 1'b0;
		rd(OFS_STATUS, 32'h00A5_0020);
		rd(OFS_CONTACT, 32'h0000_00F0);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0000_0000);
		rd(ra(5, OFS_R_TIMES), 32'h0000_0000);
		$display("test switches done");
		wr(ra(1, OFS_R_MASKS), 32'h0000_0003);
		wr(OFS_EVENTS, 32'h0000_0002);
		coil(8'h02);
		wr(OFS_EVENTS, 32'h0000_0000);
		coil(8'h00);
		$display("test normal done");
		wr(ra(2, OFS_R_TIMES), 32'h00F0_0002);
		wr(ra(2, OFS_R_CTRL), 32'h0000_8001);
		wr(ra(2, OFS_R_MASKS), 32'h0000_0004);
		wr(OFS_EVENTS, 32'h0000_0004);
		coil(8'h04);
		wr(OFS_ACK, 32'h0000_0004);
		coil(8'h04);
		secs(3);
		wr(OFS_ACK, 32'h0000_0004);
		coil(8'h00);
		secs(10);
		coil(8'h00);
		secs(6);
		coil(8'h04);
		wr(OFS_EVENTS, 32'h0000_0000);
		coil(8'h00);
		$display("test sounder done");
		wr(ra(3, OFS_R_TIMES), 32'h0000_3C00);
		wr(ra(3, OFS_R_CTRL), 32'h0000_4001);
		wr(ra(3, OFS_R_MASKS), 32'h0000_0008);
		wr(OFS_EVENTS, 32'h0000_0008);
		secs(12);
		coil(8'h08);
		secs(5);
		coil(8'h00);
		$display("test auto reset done");
		wr(ra(4, OFS_R_MASKS), 32'h0100_0010);
		wr(OFS_EVENTS, 32'h0000_0010);
		for (int k = 0; k < 4; k++) begin
			wr(ra(4, OFS_R_CTRL), 32'(2 + k * 84));
			coil({3'h0, LOGIC_EXP[k], 4'h0});
		end
		wr(ra(4, OFS_R_CTRL), 32'h0000_0002);
		$display("test logic done");
		wr(OFS_FAIL_MASK, 32'h0000_1000);
		wr(ra(5, OFS_R_MASKS), 32'h0000_1E00);
		wr(ra(5, OFS_R_CTRL), 32'h0000_0203);
		wr(OFS_EVENTS, 32'h0000_0A00);
		coil(8'h20);
		wr(OFS_EVENTS, 32'h0000_1200);
		coil(8'h00);
		wr(ra(5, OFS_R_CTRL), 32'h0000_2203);
		coil(8'h20);
		rd(ra(5, OFS_R_CTRL), 32'h0000_2203);
		$display("test vote done");
		close_out();
	end
endmodule : arim_relay_module_tb
`default_nettype wire
